// >>> shared/port_pin_reg_pkg.sv
// constants for the eight-bit general-purpose port
package port_pin_reg_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LAT_RESET = 8'h00;
  // adc pin-config field: selected pins are analog after reset
  localparam logic [3:0] ADC_CFG_RESET = 4'h0;
  localparam logic [3:0] ADC_CFG_ALL_DIGITAL = 4'hF;
  // comparator mode code that turns the comparators off
  localparam logic [2:0] CMP_MODE_OFF = 3'h7;
  localparam logic [2:0] CMP_MODE_RESET = 3'h7;
  // oscillator mode codes
  localparam logic [3:0] OSC_LP = 4'h0;
  localparam logic [3:0] OSC_XT = 4'h1;
  localparam logic [3:0] OSC_HS = 4'h2;
  localparam logic [3:0] OSC_RC = 4'h3;
  localparam logic [3:0] OSC_EC = 4'h4;
  localparam logic [3:0] OSC_EC_IO = 4'h5;
  localparam logic [3:0] OSC_HSPLL = 4'h6;
  localparam logic [3:0] OSC_RC_IO = 4'h7;
  localparam logic [3:0] OSC_INT_IO2 = 4'h8;
  localparam logic [3:0] OSC_INT_IO1 = 4'h9;
  // pin numbers
  localparam int PIN_VREF_OUT = 2;
  localparam int PIN_CMP_ONE = 4;
  localparam int PIN_CMP_TWO = 5;
  localparam int PIN_OSC_OUT = 6;
  localparam int PIN_OSC_IN = 7;
  localparam int SYNC_STAGES = 2;
endpackage

// >>> src/level_sync.sv
// two-stage synchroniser for one pin level
`timescale 1ns/1ps
module level_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> src/port_bit_mux.sv
// per-pin drive and read-back selection
`timescale 1ns/1ps
module port_bit_mux (
  // pin controls
  input wire logic dir_in,
  input wire logic latch_in,
  input wire logic pin_level,
  // overrides
  input wire logic analog_sel,
  input wire logic periph_drive,
  input wire logic periph_data,
  input wire logic pin_off,
  // results
  output logic drive_en,
  output logic drive_val,
  output logic read_val
);
  always_comb begin
    // analog selection does not stop the digital driver
    drive_en = !pin_off && (periph_drive || !dir_in);
    drive_val = periph_drive ? periph_data : latch_in;
    read_val = (pin_off || analog_sel) ? 1'b0 : pin_level;
  end
endmodule

// >>> src/port_a_io.sv
// eight-bit bidirectional general-purpose port with shared pins
// Overview of operation
// - direction 1 tri-states pin, 0 drives latch
// - pin register reads pins, writes the latch
// - latch register reads back latched output values
// - pins 6,7 read zero unless oscillator allows
// - adc config selects analog on pins 0-3,5
// - analog-selected pin reads as zero
// - direction 0 drives latch even when analog
// - reset: pins 0-3,5 analog, pin 4 input
// - reference output disables pin 2 digital io
// - enabled peripheral takes over shared pin
// - comparator outputs override latch on pins 4,5
// - pin 6 port only in three io modes
`timescale 1ns/1ps
module port_a_io (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // software access to the port registers
  input wire logic dir_wr,
  input wire logic pin_wr,
  input wire logic latch_wr,
  input wire logic [7:0] wr_data,
  output logic [7:0] port_direction_reg,
  output logic [7:0] port_pin_reg,
  output logic [7:0] port_output_latch,
  // configuration
  input wire logic adc_cfg_wr,
  input wire logic [3:0] adc_pin_config_reg,
  input wire logic [2:0] cmp_mode,
  input wire logic cmp_one_out_en,
  input wire logic cmp_two_out_en,
  input wire logic comparator_one_out,
  input wire logic comparator_two_out,
  input wire logic comparator_ref_out_en,
  input wire logic [3:0] osc_mode,
  // board pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // alternate function status
  output logic [4:0] analog_sel_out,
  output logic timer_ext_clock_in,
  output logic cmp_inputs_active
);
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] lat_q;
  logic [7:0] lat_d;
  logic [3:0] adc_q;
  logic [3:0] adc_d;
  logic [7:0] pin_sync;
  logic [7:0] drive_en;
  logic [7:0] drive_val;
  logic [7:0] read_val;
  logic [7:0] analog_sel;
  logic [7:0] periph_drive;
  logic [7:0] periph_data;
  logic [7:0] pin_off;
  logic [7:0] bit_ok;
  logic pin6_ok;
  logic pin7_ok;
  logic [7:0] oe_q;
  logic [7:0] oe_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [7:0] rd_pin_q;
  logic [7:0] rd_pin_d;
  logic [7:0] rd_dir_q;
  logic [7:0] rd_dir_d;
  logic [7:0] rd_lat_q;
  logic [7:0] rd_lat_d;
  logic [4:0] ana_q;
  logic [4:0] ana_d;
  logic tck_q;
  logic tck_d;
  logic cmp_q;
  logic cmp_d;

  // oscillator decides which of the top two pins are port pins;
  // the oscillator input pin stays a port pin only with an internal clock
  always_comb begin
    pin6_ok = 1'b0;
    pin7_ok = 1'b0;
    case (osc_mode)
      port_pin_reg_pkg::OSC_LP: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_XT: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_HS: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_RC: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_EC: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_EC_IO: begin
        pin6_ok = 1'b1;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_HSPLL: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_RC_IO: begin
        pin6_ok = 1'b1;
        pin7_ok = 1'b0;
      end
      port_pin_reg_pkg::OSC_INT_IO2: begin
        pin6_ok = 1'b1;
        pin7_ok = 1'b1;
      end
      port_pin_reg_pkg::OSC_INT_IO1: begin
        pin6_ok = 1'b0;
        pin7_ok = 1'b1;
      end
      default: begin
        // unused codes leave both pins to the oscillator
        pin6_ok = 1'b0;
        pin7_ok = 1'b0;
      end
    endcase
    bit_ok = {pin7_ok, pin6_ok, 6'h3F};
  end

  // direction register
  always_comb begin
    dir_d = dir_q;
    if (dir_wr) begin
      dir_d = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir_q <= port_pin_reg_pkg::DIR_RESET;
    end else begin
      dir_q <= dir_d;
    end
  end

  // output latch: a pin-register write lands here as well
  always_comb begin
    lat_d = lat_q;
    if (pin_wr || latch_wr) begin
      lat_d = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lat_q <= port_pin_reg_pkg::LAT_RESET;
    end else begin
      lat_q <= lat_d;
    end
  end

  // analog pin configuration
  always_comb begin
    adc_d = adc_q;
    if (adc_cfg_wr) begin
      adc_d = adc_pin_config_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      adc_q <= port_pin_reg_pkg::ADC_CFG_RESET;
    end else begin
      adc_q <= adc_d;
    end
  end

  // analog selection: config below all-digital makes pins analog;
  // a larger code frees more pins, pin 5 goes first
  always_comb begin
    analog_sel = 8'h00;
    // codes up to 9 keep all five pins analog
    case (adc_q)
      4'hA: begin
        analog_sel[3:0] = 4'hF;
      end
      4'hB: begin
        analog_sel[3:0] = 4'hF;
      end
      4'hC: begin
        analog_sel[2:0] = 3'h7;
      end
      4'hD: begin
        analog_sel[1:0] = 2'h3;
      end
      4'hE: begin
        analog_sel[0] = 1'b1;
      end
      4'hF: begin
        analog_sel = 8'h00;
      end
      default: begin
        analog_sel[3:0] = 4'hF;
        analog_sel[5] = 1'b1;
      end
    endcase
    // comparators in use keep pins 0-3 analog for digital reads
    if (cmp_mode != port_pin_reg_pkg::CMP_MODE_OFF) begin
      analog_sel[3:0] = 4'hF;
    end
    periph_drive = 8'h00;
    periph_data = 8'h00;
    periph_drive[port_pin_reg_pkg::PIN_CMP_ONE] = cmp_one_out_en;
    periph_data[port_pin_reg_pkg::PIN_CMP_ONE] = comparator_one_out;
    periph_drive[port_pin_reg_pkg::PIN_CMP_TWO] = cmp_two_out_en;
    periph_data[port_pin_reg_pkg::PIN_CMP_TWO] = comparator_two_out;
    pin_off = ~bit_ok;
    pin_off[port_pin_reg_pkg::PIN_VREF_OUT] = comparator_ref_out_en;
  end

  genvar gi;
  generate
    for (gi = 0; gi < port_pin_reg_pkg::PORT_W; gi++) begin : g_bit
      level_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(pin_in[gi]),
        .sync_out(pin_sync[gi])
      );
      port_bit_mux u_mux (
        .dir_in(dir_q[gi]),
        .latch_in(lat_q[gi]),
        .pin_level(pin_sync[gi]),
        .analog_sel(analog_sel[gi]),
        .periph_drive(periph_drive[gi]),
        .periph_data(periph_data[gi]),
        .pin_off(pin_off[gi]),
        .drive_en(drive_en[gi]),
        .drive_val(drive_val[gi]),
        .read_val(read_val[gi])
      );
    end
  endgenerate

  // registered pin drive
  always_comb begin
    oe_d = drive_en;
    out_d = drive_val & drive_en;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oe_q <= 8'h00;
      out_q <= 8'h00;
    end else begin
      oe_q <= oe_d;
      out_q <= out_d;
    end
  end

  // registered read-back values
  always_comb begin
    rd_pin_d = read_val & bit_ok;
    rd_dir_d = dir_q & bit_ok;
    rd_lat_d = lat_q & bit_ok;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_pin_q <= 8'h00;
      rd_dir_q <= 8'h00;
      rd_lat_q <= 8'h00;
    end else begin
      rd_pin_q <= rd_pin_d;
      rd_dir_q <= rd_dir_d;
      rd_lat_q <= rd_lat_d;
    end
  end

  // registered alternate function status
  always_comb begin
    ana_d = {analog_sel[5], analog_sel[3:0]};
    // timer clock input sees the digital level of pin 4
    tck_d = pin_sync[port_pin_reg_pkg::PIN_CMP_ONE];
    cmp_d = cmp_mode != port_pin_reg_pkg::CMP_MODE_OFF;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ana_q <= 5'h1F;
      tck_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      ana_q <= ana_d;
      tck_q <= tck_d;
      cmp_q <= cmp_d;
    end
  end

  assign pin_oe = oe_q;
  assign pin_out = out_q;
  assign port_pin_reg = rd_pin_q;
  assign port_direction_reg = rd_dir_q;
  assign port_output_latch = rd_lat_q;
  assign analog_sel_out = ana_q;
  assign timer_ext_clock_in = tck_q;
  assign cmp_inputs_active = cmp_q;
endmodule

// >>> testbench/port_a_io_sva.sv
// concurrent checks on the port's pins and read-back values
`timescale 1ns/1ps
module port_a_io_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // writes
  input wire logic pin_wr,
  input wire logic latch_wr,
  input wire logic [7:0] wr_data,
  // read-back
  input wire logic [7:0] port_direction_reg,
  input wire logic [7:0] port_pin_reg,
  input wire logic [7:0] port_output_latch,
  // overrides
  input wire logic cmp_one_out_en,
  input wire logic cmp_two_out_en,
  input wire logic comparator_two_out,
  input wire logic [3:0] osc_mode,
  // pins
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [4:0] analog_sel_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // the read path is only defined once the sync flops saw clean edges
  sequence s_run; rst_n [*4]; endsequence
  sequence s_ana; analog_sel_out[0] [*4]; endsequence
  property p_rst; !$past(rst_n) |->
    analog_sel_out == 5'h1F && pin_oe == 8'h00; endproperty
  property p_oe; $past(rst_n) |-> pin_oe[1:0] == ~port_direction_reg[1:0]
    && pin_out[1:0] == (port_output_latch[1:0] & pin_oe[1:0]); endproperty
  property p_oe4; $past(rst_n) && $past(cmp_one_out_en) ==
    $past(cmp_one_out_en, 2) |-> pin_oe[4] ==
    (!port_direction_reg[4] || $past(cmp_one_out_en)); endproperty
  property p_latch; (pin_wr || latch_wr) |->
    ##2 port_output_latch[5:0] == $past(wr_data[5:0], 2); endproperty
  property p_osc; $past(osc_mode) == port_pin_reg_pkg::OSC_LP &&
    $past(osc_mode, 2) == port_pin_reg_pkg::OSC_LP |-> pin_oe[7:6] == 2'h0 &&
    port_direction_reg[7:6] == 2'h0 && port_output_latch[7:6] == 2'h0;
  endproperty
  property p_ana; s_ana |-> port_pin_reg[0] == 1'b0; endproperty
  property p_cmp2; $past(cmp_two_out_en) && $past(cmp_two_out_en, 2) |->
    pin_oe[5] && pin_out[5] == $past(comparator_two_out); endproperty
  property p_sync; s_run |-> port_pin_reg[4] == $past(pin_in[4], 3);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_oe: assert property (p_oe) else $error("drive wrong");
  a_oe4: assert property (p_oe4) else $error("pin 4 drive wrong");
  a_latch: assert property (p_latch) else $error("latch wrong");
  a_osc: assert property (p_osc) else $error("osc pins wrong");
  a_ana: assert property (p_ana) else $error("analog read wrong");
  a_cmp2: assert property (p_cmp2) else $error("pin 5 wrong");
  a_sync: assert property (p_sync) else $error("sync wrong");
endmodule
bind port_a_io port_a_io_sva u_port_a_io_sva (.clk_sys, .rst_n, .pin_wr,
  .latch_wr, .wr_data, .port_direction_reg, .port_pin_reg,
  .port_output_latch, .cmp_one_out_en, .cmp_two_out_en,
  .comparator_two_out, .osc_mode, .pin_in, .pin_out, .pin_oe,
  .analog_sel_out);

// >>> testbench/board_pins.sv
// board side of the port pins
`timescale 1ns/1ps
module board_pins (
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // board side
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // board drives weakly; a driving device pin wins on its own line
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> testbench/test_port_a_io.sv
// self-checking bench for the eight-bit port
`timescale 1ns/1ps
module test_port_a_io;
  logic clk_sys = 0, rst_n = 0, dir_wr = 0, pin_wr = 0, latch_wr = 0;
  logic adc_cfg_wr = 0, cmp_one_out_en = 0, cmp_two_out_en = 0;
  logic comparator_one_out = 0, comparator_two_out = 0;
  logic comparator_ref_out_en = 0, timer_ext_clock_in, cmp_inputs_active;
  logic [7:0] wr_data = 8'h00, ext_level = 8'hD5, pin_in, pin_out, pin_oe;
  logic [7:0] port_direction_reg, port_pin_reg, port_output_latch;
  logic [3:0] adc_pin_config_reg = 4'h0, osc_mode = port_pin_reg_pkg::OSC_INT_IO2;
  logic [2:0] cmp_mode = port_pin_reg_pkg::CMP_MODE_RESET;
  logic [4:0] analog_sel_out, ea;
  logic [1:0] eo;
  int fails = 0, n_checks = 0;
  always #2 clk_sys = ~clk_sys;
  port_a_io u_port_a_io (.clk_sys, .rst_n, .dir_wr, .pin_wr, .latch_wr,
    .wr_data, .port_direction_reg, .port_pin_reg, .port_output_latch,
    .adc_cfg_wr, .adc_pin_config_reg, .cmp_mode, .cmp_one_out_en,
    .cmp_two_out_en, .comparator_one_out, .comparator_two_out,
    .comparator_ref_out_en, .osc_mode, .pin_in, .pin_out, .pin_oe,
    .analog_sel_out, .timer_ext_clock_in, .cmp_inputs_active);
  board_pins u_board_pins (.pin_out, .pin_oe, .ext_level, .pin_in);
  task summarize;
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // k = {adc_cfg_wr, dir_wr, pin_wr, latch_wr}; waits out the pin path
  task wr(input logic [3:0] k, input logic [7:0] d);
    @(posedge clk_sys);
    {adc_cfg_wr, dir_wr, pin_wr, latch_wr} <= k;
    wr_data <= d;
    adc_pin_config_reg <= d[3:0];
    @(posedge clk_sys);
    {adc_cfg_wr, dir_wr, pin_wr, latch_wr} <= 4'h0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1;
    wr(4'h0, 8'h00);
    chk(port_direction_reg, 8'hFF);
    chk({3'h0, analog_sel_out}, 8'h1F);
    chk(port_pin_reg, 8'hD0);
    chk({7'h0, timer_ext_clock_in}, 8'h01);
    chk({7'h0, cmp_inputs_active}, 8'h00);
    wr(4'h1, 8'h3C);
    wr(4'h4, 8'h00);
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h3C);
    chk(port_pin_reg, 8'h10);
    wr(4'h2, 8'hC3);
    chk(port_output_latch, 8'hC3);
    chk(port_pin_reg, 8'hC0);
    wr(4'h4, 8'hFF);
    @(posedge clk_sys) cmp_mode <= 3'h0;
    wr(4'h8, {4'h0, port_pin_reg_pkg::ADC_CFG_ALL_DIGITAL});
    chk(port_pin_reg, 8'hD0);
    chk({7'h0, cmp_inputs_active}, 8'h01);
    @(posedge clk_sys) cmp_mode <= port_pin_reg_pkg::CMP_MODE_OFF;
    for (int c = 0; c < 16; c++) begin
      wr(4'h8, 8'(c));
      ea = {c <= 9, c <= 11, c <= 12, c <= 13, c <= 14};
      chk({3'h0, analog_sel_out}, {3'h0, ea});
      chk(port_pin_reg, 8'hD5 & ~{2'h0, ea[4], 1'b0, ea[3:0]});
    end
    for (int m = 0; m < 10; m++) begin
      @(posedge clk_sys) osc_mode <= 4'(m);
      wr(4'h0, 8'h00);
      eo = {m == 8 || m == 9, m == 5 || m == 7 || m == 8};
      chk(port_direction_reg, {eo, 6'h3F});
      chk(port_pin_reg, {eo, 6'h15});
    end
    wr(4'h1, 8'hFF);
    @(posedge clk_sys) osc_mode <= port_pin_reg_pkg::OSC_INT_IO2;
    comparator_ref_out_en <= 1;
    cmp_one_out_en <= 1;
    cmp_two_out_en <= 1;
    wr(4'h0, 8'h00);
    chk(pin_oe, 8'h30);
    chk(pin_out, 8'h00);
    chk(port_pin_reg, 8'hC1);
    chk({7'h0, timer_ext_clock_in}, 8'h00);
    wr(4'h4, 8'h00);
    chk(pin_oe, 8'hFB);
    chk(pin_out, 8'hCB);
    chk(port_pin_reg, 8'hCB);
    @(posedge clk_sys) {comparator_ref_out_en, cmp_one_out_en} <= 2'h0;
    cmp_two_out_en <= 0;
    rst_n <= 0;
    @(posedge clk_sys) rst_n <= 1;
    wr(4'h0, 8'h00);
    chk(pin_oe, 8'h00);
    chk(port_output_latch, 8'h00);
    chk({3'h0, analog_sel_out}, 8'h1F);
    summarize;
  end
  initial begin
    #10000;
    fails++;
    summarize;
  end
endmodule
